/* rtl/fdc_cmd_regs.svh */
// constants for the floppy command interpreter
`ifndef FDC_CMD_REGS_SVH
`define FDC_CMD_REGS_SVH
`define OFS_DATA        4'h0
`define OFS_MSR         4'h1
`define OFS_IRQ_STAT    4'h2
`define OFS_IRQ_MASK    4'h3
`define OFS_EXEC_STAT   4'h4
`define OFS_EXEC_CTRL   4'h5
`define OP_MASK         8'h1F
`define OP_READ_ID      8'h0A
`define OP_VERIFY       8'h16
`define OP_VERSION      8'h10
`define OP_WRITE_DATA   8'h05
`define OP_WRITE_DEL    8'h09
`define BIT_MULTI_TRACK 7
`define BIT_DENSITY     6
`define BIT_SKIP_DEL    5
`define BIT_COUNT_EN    7
// arbitrary identifying value for the version answer
`define VERSION_CODE    8'h5A
`define LEN_RW          4'h9
`define LEN_RID         4'h2
`define LEN_RES         3'h7
`define IRQ_RESULT      0
`define IRQ_BADCMD      1
`define IRQ_WIDTH       2
`endif

/* rtl/fdc_cmd_pkg.sv */
// types for the floppy command interpreter
package fdc_cmd_pkg;
    typedef enum logic [4:0] {
        ST_CMD    = 5'b0_0001,
        ST_EXEC   = 5'b0_0010,
        ST_RESULT = 5'b0_0100,
        ST_WDATA  = 5'b0_1000,
        ST_VDONE  = 5'b1_0000
    } phase_t;
    typedef enum logic [2:0] {
        K_NONE, K_READ_ID, K_VERIFY, K_VERSION, K_WRITE, K_WRITE_DEL
    } cmd_kind_t;
endpackage

/* rtl/fdc_drive_if.sv */
// drive-side signals between interpreter and execution helper
`timescale 1ns/1ps
`default_nettype none
interface fdc_drive_if;
    logic       start;
    logic [2:0] kind;
    logic       id_valid;
    logic       id_ok;
    logic [7:0] id_c;
    logic [7:0] id_h;
    logic [7:0] id_r;
    logic [7:0] id_n;
    logic       done;
    logic       id_found;
    logic [7:0] cap_c;
    logic [7:0] cap_h;
    logic [7:0] cap_r;
    logic [7:0] cap_n;
    modport ctl (output start, output kind, input done, input id_found,
                 input cap_c, input cap_h, input cap_r, input cap_n);
    modport exe (input start, input kind, input id_valid, input id_ok, input id_c,
                 input id_h, input id_r, input id_n, output done, output id_found,
                 output cap_c, output cap_h, output cap_r, output cap_n);
endinterface
`default_nettype wire

/* rtl/fdc_id_capture.sv */
// captures the first good sector identifier during read-identifier
`timescale 1ns/1ps
`default_nettype none
module fdc_id_capture
    import fdc_cmd_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic exec_done,
    fdc_drive_if.exe  drv
);
    logic armed_q;
    logic live;
    logic hit;
    // live in the start cycle too, so an early good id is not missed
    assign live = armed_q || drv.start;
    assign hit = live && drv.id_valid && drv.id_ok;
    assign drv.done = (live && drv.kind == 3'(K_READ_ID)) ? hit : (live && exec_done);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_q      <= 1'b0;
            drv.id_found <= 1'b0;
            drv.cap_c    <= 8'h00;
            drv.cap_h    <= 8'h00;
            drv.cap_r    <= 8'h00;
            drv.cap_n    <= 8'h00;
        end else begin
            armed_q <= live && !drv.done;
            if (drv.start) begin
                drv.id_found <= 1'b0;
            end
            if (hit) begin
                drv.id_found <= 1'b1;
                drv.cap_c    <= drv.id_c;
                drv.cap_h    <= drv.id_h;
                drv.cap_r    <= drv.id_r;
                drv.cap_n    <= drv.id_n;
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/fdc_result_mux.sv */
// selects the result byte by position
`timescale 1ns/1ps
`default_nettype none
module fdc_result_mux (
    input  wire logic [2:0] idx,
    input  wire logic       single,
    input  wire logic [7:0] single_byte,
    input  wire logic [7:0] st_a,
    input  wire logic [7:0] st_b,
    input  wire logic [7:0] st_c,
    input  wire logic [7:0] id_c,
    input  wire logic [7:0] id_h,
    input  wire logic [7:0] id_r,
    input  wire logic [7:0] id_n,
    output logic      [7:0] sel
);
    logic [7:0] seq;
    assign seq = (idx == 3'd0) ? st_a : (idx == 3'd1) ? st_b : (idx == 3'd2) ? st_c :
                 (idx == 3'd3) ? id_c : (idx == 3'd4) ? id_h : (idx == 3'd5) ? id_r : id_n;
    assign sel = single ? single_byte : seq;
endmodule
`default_nettype wire

/* rtl/fdc_cmd_decode.sv */
// command/result sequencer for read-id, verify, version and writes
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fdc_cmd_regs.svh"
module fdc_cmd_decode
    import fdc_cmd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    output logic            irq,
    input  wire logic       id_valid,
    input  wire logic       id_ok,
    input  wire logic [7:0] id_c,
    input  wire logic [7:0] id_h,
    input  wire logic [7:0] id_r,
    input  wire logic [7:0] id_n,
    input  wire logic       exec_done,
    input  wire logic [7:0] exec_st_a,
    input  wire logic [7:0] exec_st_b,
    input  wire logic [7:0] exec_st_c,
    input  wire logic [7:0] exec_c,
    input  wire logic [7:0] exec_h,
    input  wire logic [7:0] exec_r,
    input  wire logic [7:0] exec_n,
    output logic            disk_wr_valid,
    output logic      [7:0] disk_wr_data,
    output logic            disk_rd_xfer
);
    function automatic cmd_kind_t decode_op(input logic [7:0] op);
        logic [7:0] lo;
        lo = op & `OP_MASK;
        if (op == `OP_VERSION) decode_op = K_VERSION;
        else if (lo == `OP_READ_ID && !op[7] && !op[5]) decode_op = K_READ_ID;
        else if (lo == `OP_VERIFY) decode_op = K_VERIFY;
        else if (lo == `OP_WRITE_DATA && !op[5]) decode_op = K_WRITE;
        else if (lo == `OP_WRITE_DEL && !op[5]) decode_op = K_WRITE_DEL;
        else decode_op = K_NONE;
    endfunction

    phase_t     phase_q;
    cmd_kind_t  kind_q;
    logic [3:0] cnt_q;
    logic [2:0] ridx_q;
    logic [7:0] prm_q [0:8];
    logic [7:0] rdata_q;
    logic [7:0] st_a_q;
    logic [7:0] st_b_q;
    logic [7:0] st_c_q;
    logic [7:0] res_c_q;
    logic [7:0] res_h_q;
    logic [7:0] res_r_q;
    logic [7:0] res_n_q;
    logic [`IRQ_WIDTH-1:0] irq_stat_q;
    logic [`IRQ_WIDTH-1:0] irq_mask_q;
    logic [7:0] exec_ctrl_q;
    logic       start_q;
    logic       wdata_vld_q;
    logic [7:0] wdata_q;

    fdc_drive_if drv();

    wire data_wr   = wr_stb && addr == `OFS_DATA;
    wire data_rd   = rd_stb && addr == `OFS_DATA;
    wire cmd_wr    = data_wr && phase_q == ST_CMD;
    wire first_wr  = cmd_wr && cnt_q == 4'd0;
    wire cmd_kind_t new_kind = decode_op(wdata);
    wire [3:0] need = (kind_q == K_READ_ID) ? `LEN_RID : `LEN_RW;
    wire last_prm  = cmd_wr && cnt_q != 4'd0 && cnt_q == need - 4'd1;
    wire ver_cmd   = first_wr && new_kind == K_VERSION;
    wire bad_cmd   = first_wr && new_kind == K_NONE;
    wire res_rd    = data_rd && phase_q == ST_RESULT;
    wire single    = kind_q == K_VERSION;
    wire res_last  = res_rd && (single || ridx_q == `LEN_RES - 3'd1);
    wire is_write  = kind_q == K_WRITE || kind_q == K_WRITE_DEL;
    wire wr_stream = data_wr && phase_q == ST_EXEC && is_write;
    wire [`IRQ_WIDTH-1:0] irq_ev = {bad_cmd, res_last};
    wire [7:0] res_byte;
    wire [7:0] msr = {phase_q == ST_CMD || (phase_q == ST_EXEC && is_write),
                      phase_q == ST_RESULT, phase_q == ST_EXEC, phase_q != ST_CMD, 1'b0, kind_q};

    assign drv.start = start_q;
    assign drv.kind  = kind_q;
    assign drv.id_valid = id_valid;
    assign drv.id_ok = id_ok;
    assign drv.id_c  = id_c;
    assign drv.id_h  = id_h;
    assign drv.id_r  = id_r;
    assign drv.id_n  = id_n;

    fdc_id_capture u_cap (
        .clk       (clk),
        .reset_n   (reset_n),
        .exec_done (exec_done),
        .drv       (drv.exe)
    );

    fdc_result_mux u_mux (
        .idx         (ridx_q),
        .single      (single),
        .single_byte (`VERSION_CODE),
        .st_a        (st_a_q),
        .st_b        (st_b_q),
        .st_c        (st_c_q),
        .id_c        (res_c_q),
        .id_h        (res_h_q),
        .id_r        (res_r_q),
        .id_n        (res_n_q),
        .sel         (res_byte)
    );

    wire [7:0] rd_mux = (addr == `OFS_DATA)      ? (phase_q == ST_RESULT ? res_byte : 8'h00) :
                        (addr == `OFS_MSR)       ? msr :
                        (addr == `OFS_IRQ_STAT)  ? {6'h00, irq_stat_q} :
                        (addr == `OFS_IRQ_MASK)  ? {6'h00, irq_mask_q} :
                        (addr == `OFS_EXEC_STAT) ? {7'h00, drv.id_found} :
                        (addr == `OFS_EXEC_CTRL) ? exec_ctrl_q : 8'h00;

    assign rdata = rdata_q;
    assign irq = |(irq_stat_q & irq_mask_q);
    assign disk_wr_valid = wdata_vld_q;
    assign disk_wr_data = wdata_q;
    assign disk_rd_xfer = 1'b0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q     <= 8'h00;
            irq_stat_q  <= '0;
            irq_mask_q  <= '0;
            exec_ctrl_q <= 8'h00;
            wdata_vld_q <= 1'b0;
            wdata_q     <= 8'h00;
        end else begin
            rdata_q     <= rd_stb ? rd_mux : 8'h00;
            irq_stat_q  <= (irq_stat_q & ~((wr_stb && addr == `OFS_IRQ_STAT) ? wdata[1:0] : 2'b00)) | irq_ev;
            if (wr_stb && addr == `OFS_IRQ_MASK) irq_mask_q <= wdata[1:0];
            if (wr_stb && addr == `OFS_EXEC_CTRL) exec_ctrl_q <= wdata;
            wdata_vld_q <= wr_stream;
            if (wr_stream) wdata_q <= wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= ST_CMD;
            kind_q  <= K_NONE;
            cnt_q   <= 4'd0;
            ridx_q  <= 3'd0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (phase_q)
                ST_CMD: begin
                    if (ver_cmd) begin
                        kind_q  <= K_VERSION;
                        ridx_q  <= 3'd0;
                        phase_q <= ST_RESULT;
                    end else if (first_wr && !bad_cmd) begin
                        kind_q <= new_kind;
                        cnt_q  <= 4'd1;
                    end else if (last_prm) begin
                        cnt_q   <= 4'd0;
                        start_q <= 1'b1;
                        phase_q <= ST_EXEC;
                    end else if (cmd_wr && cnt_q != 4'd0) begin
                        cnt_q <= cnt_q + 4'd1;
                    end
                end
                ST_EXEC: begin
                    if (drv.done) begin
                        ridx_q  <= 3'd0;
                        phase_q <= ST_RESULT;
                    end
                end
                ST_RESULT: begin
                    if (res_last) begin
                        kind_q  <= K_NONE;
                        phase_q <= ST_CMD;
                    end else if (res_rd) begin
                        ridx_q <= ridx_q + 3'd1;
                    end
                end
                default: phase_q <= ST_CMD;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 9; i++) prm_q[i] <= 8'h00;
            st_a_q  <= 8'h00;
            st_b_q  <= 8'h00;
            st_c_q  <= 8'h00;
            res_c_q <= 8'h00;
            res_h_q <= 8'h00;
            res_r_q <= 8'h00;
            res_n_q <= 8'h00;
        end else begin
            if (cmd_wr) prm_q[cnt_q] <= wdata;
            if (phase_q == ST_EXEC && drv.done) begin
                st_a_q <= exec_st_a;
                st_b_q <= exec_st_b;
                st_c_q <= exec_st_c;
                if (kind_q == K_READ_ID) begin
                    res_c_q <= id_c;
                    res_h_q <= id_h;
                    res_r_q <= id_r;
                    res_n_q <= id_n;
                end else begin
                    res_c_q <= exec_c;
                    res_h_q <= exec_h;
                    res_r_q <= exec_r;
                    res_n_q <= exec_n;
                end
            end
        end
    end

    // read-identifier: capture on the ending cycle, kept through the result
    AST_RID_RESULT: assert property (@(posedge clk) disable iff (!reset_n)
        (phase_q == ST_EXEC && kind_q == K_READ_ID && drv.done)
        |=> phase_q == ST_RESULT && res_c_q == $past(id_c) && res_n_q == $past(id_n))
        else $error("read id result not captured");

    AST_RID_FIRST: assert property (@(posedge clk) disable iff (!reset_n)
        (phase_q == ST_EXEC && kind_q == K_READ_ID && id_valid && id_ok) |-> drv.done)
        else $error("good id did not end read id");

    AST_RID_HELD: assert property (@(posedge clk) disable iff (!reset_n)
        (phase_q == ST_RESULT && kind_q == K_READ_ID)
        |-> drv.id_found && {drv.cap_c, drv.cap_h, drv.cap_r, drv.cap_n} == {res_c_q, res_h_q, res_r_q, res_n_q})
        else $error("captured id lost before result");

    // version: straight to a one-byte result
    AST_VER_ONE: assert property (@(posedge clk) disable iff (!reset_n)
        ver_cmd |=> phase_q == ST_RESULT && single)
        else $error("version did not enter result phase");

    AST_VER_CODE: assert property (@(posedge clk) disable iff (!reset_n)
        (res_rd && single) |=> rdata == `VERSION_CODE && phase_q == ST_CMD)
        else $error("version answer wrong");

    // data path: verify moves nothing, writes pass each byte on
    AST_NO_READ_XFER: assert property (@(posedge clk) disable iff (!reset_n)
        (kind_q == K_VERIFY) |-> !disk_wr_valid && !disk_rd_xfer)
        else $error("verify moved data");

    AST_WR_STREAM: assert property (@(posedge clk) disable iff (!reset_n)
        wr_stream |=> disk_wr_valid && disk_wr_data == $past(wdata))
        else $error("write byte not passed on");

    AST_RES_SEVEN: assert property (@(posedge clk) disable iff (!reset_n)
        (res_rd && !single && ridx_q == 3'd6) |=> phase_q == ST_CMD)
        else $error("result did not end after seven");

    // command lengths
    AST_RW_NINE: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_wr && kind_q == K_WRITE_DEL && cnt_q == 4'd8) |=> phase_q == ST_EXEC && start_q)
        else $error("write deleted length wrong");

    AST_WRITE_NINE: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_wr && kind_q == K_WRITE && cnt_q == 4'd8) |=> phase_q == ST_EXEC && start_q)
        else $error("write data length wrong");

    AST_VERIFY_NINE: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_wr && kind_q == K_VERIFY && cnt_q == 4'd8) |=> phase_q == ST_EXEC)
        else $error("verify length wrong");

    AST_RID_TWO: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd_wr && kind_q == K_READ_ID && cnt_q == 4'd1) |=> phase_q == ST_EXEC && start_q)
        else $error("read id length wrong");

    AST_OPCODE_KEPT: assert property (@(posedge clk) disable iff (!reset_n)
        first_wr |=> prm_q[0] == $past(wdata))
        else $error("opcode byte not stored");

    // unknown opcode flagged and dropped
    AST_BAD_IGNORED: assert property (@(posedge clk) disable iff (!reset_n)
        bad_cmd |=> phase_q == ST_CMD && cnt_q == 4'd0 && irq_stat_q[`IRQ_BADCMD])
        else $error("bad opcode not flagged");

    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        !rd_stb |=> rdata == 8'h00)
        else $error("read data not zero outside read");
endmodule
`default_nettype wire

/* test/fdc_drive_model.sv */
// drive-side model: sector id stream and execution completion
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        start_rid,
    input  wire logic        start_exec,
    input  wire logic [7:0]  wait_cyc,
    input  wire logic [55:0] answer,
    output logic             id_valid,
    output logic             id_ok,
    output logic      [31:0] id_f,
    output logic             exec_done,
    output logic      [23:0] exec_st,
    output logic      [31:0] exec_id
);
    logic [7:0] cnt_q;
    logic       rid_q;
    logic       exe_q;
    logic       again_q;
    assign exec_st = answer[55:32];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {cnt_q, rid_q, exe_q, again_q, id_valid, id_ok, exec_done} <= '0;
            id_f    <= '0;
            exec_id <= '0;
        end else begin
            id_valid  <= 1'b0;
            id_ok     <= 1'b0;
            exec_done <= 1'b0;
            again_q   <= 1'b0;
            id_f      <= ~id_f;
            exec_id   <= ~answer[31:0];
            if (again_q) begin
                // a later good id that must not replace the first
                id_valid <= 1'b1;
                id_ok    <= 1'b1;
                id_f     <= ~answer[31:0];
            end
            if (start_rid || start_exec) begin
                cnt_q <= wait_cyc;
                rid_q <= start_rid;
                exe_q <= start_exec;
            end else if (rid_q || exe_q) begin
                cnt_q <= cnt_q - 8'h01;
                if (rid_q && cnt_q == 8'h02) begin
                    id_valid <= 1'b1;
                    id_f     <= ~answer[31:0];
                end
                if (cnt_q == 8'h00) begin
                    rid_q     <= 1'b0;
                    exe_q     <= 1'b0;
                    again_q   <= rid_q;
                    id_valid  <= rid_q;
                    id_ok     <= rid_q;
                    id_f      <= answer[31:0];
                    exec_done <= exe_q;
                    exec_id   <= answer[31:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* test/disk_ctrl_cmd_decode_rw_verify_test.sv */
// self-checking bench for the floppy command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "fdc_cmd_regs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); end end
module disk_ctrl_cmd_decode_rw_verify_test;
    logic        clk, reset_n, wr_stb, rd_stb, irq, start_rid, start_exec;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, d, b, op, wait_cyc, disk_wr_data;
    logic        disk_wr_valid, disk_rd_xfer, id_valid, id_ok, exec_done;
    logic [31:0] rng, f, id_f, exec_id;
    logic [23:0] exec_st;
    logic [55:0] answer;
    logic [63:0] v;
    logic [7:0]  q[$];
    logic [4:0]  low5[3] = '{5'b10110, 5'b00101, 5'b01001};
    logic [3:0]  zregs[5] = '{`OFS_IRQ_STAT, `OFS_IRQ_MASK, `OFS_DATA, 4'hF, `OFS_EXEC_STAT};
    integer      err_total, checked;

    fdc_cmd_decode fdc_cmd_decode_inst (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .id_valid(id_valid), .id_ok(id_ok),
        .id_c(id_f[31:24]), .id_h(id_f[23:16]), .id_r(id_f[15:8]), .id_n(id_f[7:0]),
        .exec_done(exec_done), .exec_st_a(exec_st[23:16]), .exec_st_b(exec_st[15:8]),
        .exec_st_c(exec_st[7:0]), .exec_c(exec_id[31:24]), .exec_h(exec_id[23:16]),
        .exec_r(exec_id[15:8]), .exec_n(exec_id[7:0]), .disk_wr_valid(disk_wr_valid),
        .disk_wr_data(disk_wr_data), .disk_rd_xfer(disk_rd_xfer));
    fdc_drive_model fdc_drive_model_inst (.clk(clk), .reset_n(reset_n), .start_rid(start_rid),
        .start_exec(start_exec), .wait_cyc(wait_cyc), .answer(answer), .id_valid(id_valid),
        .id_ok(id_ok), .id_f(id_f), .exec_done(exec_done), .exec_st(exec_st), .exec_id(exec_id));

    always #5 clk = ~clk;

    function automatic logic [31:0] nxt();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk);
        addr   <= a;
        wdata  <= x;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] x);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 x = rdata;
    endtask

    // new drive answer, and the bytes the host should read back
    task automatic load_answer();
        @(posedge clk);
        v = {nxt(), nxt()};
        answer <= v[55:0];
        for (int i = 6; i >= 0; i--) q.push_back(v[8*i +: 8]);
    endtask

    task automatic pulse_drive(input logic rid, input logic [7:0] w);
        @(posedge clk);
        start_rid  <= rid;
        start_exec <= !rid;
        wait_cyc   <= w;
        @(posedge clk);
        start_rid  <= 1'b0;
        start_exec <= 1'b0;
    endtask

    task automatic get_results(input int n);
        int i;
        i = 0;
        do begin
            rd(`OFS_MSR, d);
            i++;
        end while (d[6] !== 1'b1 && i < 100);
        `CHK(d[6], 1'b1)
        repeat (n) begin
            rd(`OFS_DATA, d);
            b = q.pop_front();
            `CHK(d, b)
        end
        rd(`OFS_IRQ_STAT, d);
        `CHK(d[0], 1'b1)
        `CHK(irq, 1'b1)
        wr(`OFS_IRQ_STAT, 8'h01);
        `CHK(irq, 1'b0)
        rd(`OFS_DATA, d);
        `CHK(d, 8'h00)
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #200_000;
        err_total++;
        give_verdict();
    end

    initial begin
        {clk, reset_n, wr_stb, rd_stb, start_rid, start_exec} = '0;
        {addr, wdata, wait_cyc, answer} = '0;
        err_total = 0;
        checked = 0;
        rng = 32'd6136;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(zregs[i], d);
            `CHK(d, 8'h00)
        end
        `CHK(irq, 1'b0)
        f = nxt();
        wr(`OFS_EXEC_CTRL, f[7:0]);
        wr(4'hF, f[15:8]);
        rd(`OFS_EXEC_CTRL, d);
        `CHK(d, f[7:0])
        rd(4'hF, d);
        `CHK(d, 8'h00)
        wr(`OFS_IRQ_MASK, 8'h03);
        $display("registers test done");
        for (int k = 0; k < 2; k++) begin
            load_answer();
            f = nxt();
            wr(`OFS_DATA, {1'b0, k[0], 6'b00_1010});
            wr(`OFS_DATA, {5'b0_0000, f[2:0]});
            pulse_drive(1'b1, 8'h03 + 8'(k * 10));
            get_results(7);
            rd(`OFS_EXEC_STAT, d);
            `CHK(d[0], 1'b1)
        end
        $display("read id test done");
        for (int k = 0; k < 3; k++) begin
            load_answer();
            f = nxt();
            op = (k == 0) ? {f[7:5], low5[k]} : {f[7:6], 1'b0, low5[k]};
            wr(`OFS_DATA, op);
            wr(`OFS_DATA, {(k == 0) & f[8], 4'h0, f[2:0]});
            repeat (7) begin
                f = nxt();
                wr(`OFS_DATA, f[7:0]);
            end
            pulse_drive(1'b0, 8'h28);
            rd(`OFS_MSR, d);
            `CHK(d[7:4], {k != 0, 3'b011})
            for (int j = 0; j < 3; j++) begin
                f = nxt();
                wr(`OFS_DATA, f[7:0]);
                `CHK(disk_wr_valid, k != 0)
                `CHK(disk_rd_xfer, 1'b0)
                if (k != 0) `CHK(disk_wr_data, f[7:0])
            end
            get_results(7);
        end
        $display("nine byte commands test done");
        q.push_back(`VERSION_CODE);
        wr(`OFS_DATA, 8'h10);
        get_results(1);
        wr(`OFS_DATA, 8'h03);
        rd(`OFS_IRQ_STAT, d);
        `CHK(d, 8'h02)
        `CHK(irq, 1'b1)
        wr(`OFS_IRQ_MASK, 8'h01);
        `CHK(irq, 1'b0)
        wr(`OFS_IRQ_STAT, 8'h02);
        rd(`OFS_IRQ_STAT, d);
        `CHK(d, 8'h00)
        $display("version and bad opcode test done");
        give_verdict();
    end
endmodule
`default_nettype wire
